// File: design/sdf_cfg.svh
// Constants for the sinc-cubed decimation filter
`ifndef SDF_CFG_SVH
`define SDF_CFG_SVH

// Clock periods in ns and derived master clock divider
`define SDF_CLK_NS 10
`define SDF_MCLK_NS 100
`define SDF_MCLK_DIV (`SDF_MCLK_NS / `SDF_CLK_NS)
`define SDF_MCLK_CNT_W 8

// Modulator cycle is 512 master clocks, base sample period 256
`define SDF_MOD_DIV 512
`define SDF_MOD_CNT_W 9
`define SDF_SAMP_DIV 256
`define SDF_GAIN_SHIFT_MAX 3'h3

// Filter-select word: width and legal decimation range
`define SDF_FSW_W 12
`define SDF_FSW_MIN 12'h013
`define SDF_FSW_MAX 12'h7D0
`define SDF_FSW_RST 12'h0C3

// Datapath: 1 + 3*11 bits for N up to 2000, plus guard bits
`define SDF_ACC_W 36
`define SDF_ORDER 3

// Output periods needed after a flush before words are valid
`define SDF_SETTLE_WORDS 3'h4
`define SDF_SETTLE_W 3

`endif

// File: design/sdf_pkg.sv
// Types shared by the sinc-cubed decimation filter
`include "sdf_cfg.svh"

package sdf_pkg;

    typedef logic signed [`SDF_ACC_W-1:0] sdf_acc_t;

    // Settings that force the filter to restart and settle
    typedef struct packed {
        logic [`SDF_FSW_W-1:0] filter_select_word;
        logic [2:0] gain_code;
        logic chan_sel;
    } sdf_cfg_t;

    // Conversion word with its validity mark
    typedef struct packed {
        sdf_acc_t data;
        logic valid;
    } sdf_word_t;

    typedef enum logic [1:0] {
        SDF_ST_FLUSH = 2'b00,
        SDF_ST_SETTLE = 2'b01,
        SDF_ST_RUN = 2'b10
    } sdf_state_t;

endpackage

// File: design/sdf_tick_gen.sv
// Master clock, modulator and input sampling strobes
`timescale 1ns/100ps
`include "sdf_cfg.svh"

module sdf_tick_gen (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Gain code, log2 of the gain
    input wire logic [2:0] gain_code_i,
    // Strobes
    output logic mod_tick_o,
    output logic samp_tick_o
);
    import sdf_pkg::*;

    logic [`SDF_MCLK_CNT_W-1:0] div_q;
    logic [`SDF_MCLK_CNT_W-1:0] div_d;
    logic [`SDF_MOD_CNT_W-1:0] mcnt_q;
    logic [`SDF_MOD_CNT_W-1:0] mcnt_d;
    logic mod_tick_q;
    logic samp_tick_q;

    wire mtick = (div_q == `SDF_MCLK_CNT_W'(`SDF_MCLK_DIV - 1));
    // Gains above 8 keep the 8x sample rate
    wire [2:0] shift = (gain_code_i > `SDF_GAIN_SHIFT_MAX) ? `SDF_GAIN_SHIFT_MAX : gain_code_i;
    wire [7:0] samp_mask = 8'((`SDF_SAMP_DIV - 1) >> shift);
    wire mod_wrap = (mcnt_q == `SDF_MOD_CNT_W'(`SDF_MOD_DIV - 1));
    wire samp_hit = mtick && ((mcnt_q[7:0] & samp_mask) == 8'h00); // see RQ2 RQ3
    wire mod_hit = mtick && mod_wrap; // see RQ1

    assign div_d = mtick ? '0 : div_q + 1'b1;
    assign mcnt_d = !mtick ? mcnt_q : (mod_wrap ? '0 : mcnt_q + 1'b1);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_q <= '0;
            mcnt_q <= '0;
            mod_tick_q <= 1'b0;
            samp_tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            mcnt_q <= mcnt_d;
            mod_tick_q <= mod_hit;
            samp_tick_q <= samp_hit;
        end
    end

    assign mod_tick_o = mod_tick_q;
    assign samp_tick_o = samp_tick_q;
endmodule

// File: design/sdf_sinc3.sv
// Third-order integrate-and-dump decimator core
`timescale 1ns/100ps
`include "sdf_cfg.svh"

module sdf_sinc3 (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Control
    input wire logic clear_i,
    input wire logic [`SDF_FSW_W-1:0] decim_i,
    // Modulator stream
    input wire logic tick_i,
    input wire logic bit_i,
    // Decimated output
    output logic out_stb_o,
    output sdf_pkg::sdf_acc_t out_o
);
    import sdf_pkg::*;

    sdf_acc_t integ_q [0:`SDF_ORDER-1];
    sdf_acc_t integ_in [0:`SDF_ORDER-1];
    sdf_acc_t comb_dly_q [0:`SDF_ORDER-1];
    sdf_acc_t comb_in [0:`SDF_ORDER];
    sdf_acc_t out_q;
    logic [`SDF_FSW_W-1:0] dcnt_q;
    logic out_stb_q;

    // Bipolar map keeps zero input at zero output
    wire sdf_acc_t x = bit_i ? sdf_acc_t'(1) : -sdf_acc_t'(1);
    wire dump = tick_i && (dcnt_q == decim_i - 1'b1); // see RQ6 RQ7

    assign comb_in[0] = integ_q[`SDF_ORDER-1];

    // Wraparound adders: the combs recover the exact sum
    genvar g;
    generate
        for (g = 0; g < `SDF_ORDER; g++) begin : g_stage // see RQ5
            // Split so the first stage never names a stage below zero
            if (g == 0) begin : g_first
                assign integ_in[g] = x;
            end else begin : g_next
                assign integ_in[g] = integ_q[g-1];
            end
            assign comb_in[g+1] = comb_in[g] - comb_dly_q[g];
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    integ_q[g] <= '0;
                    comb_dly_q[g] <= '0;
                end else if (clear_i) begin
                    integ_q[g] <= '0;
                    comb_dly_q[g] <= '0;
                end else begin
                    if (tick_i) integ_q[g] <= integ_q[g] + integ_in[g];
                    if (dump) comb_dly_q[g] <= comb_in[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dcnt_q <= '0;
            out_q <= '0;
            out_stb_q <= 1'b0;
        end else if (clear_i) begin
            dcnt_q <= '0;
            out_stb_q <= 1'b0;
        end else begin
            if (tick_i) dcnt_q <= dump ? '0 : dcnt_q + 1'b1;
            if (dump) out_q <= comb_in[`SDF_ORDER];
            out_stb_q <= dump;
        end
    end

    assign out_o = out_q;
    assign out_stb_o = out_stb_q;
endmodule

// File: design/sdf_top.sv
// Sinc-cubed decimating filter behind a sigma-delta modulator
//
// Summary of operation
// RQ1: Modulator strobe is master clock divided 512
// RQ2: Higher gains sample several times per cycle
// RQ3: Sample rate master/256 times gain, capped 8x
// RQ4: Cutoff set by 12-bit filter-select word
// RQ5: Third-order sinc; select moves notches only
// RQ6: Decimate modulator stream to notch rate
// RQ7: One output word per notch period
// RQ8: Step settles after four output periods
// RQ9: Words before settling are marked invalid
// RQ10: Host waits settling after channel switch
// RQ11: Datapath has headroom beyond nominal range
// RQ12: No rejection at modulator rate multiples
// RQ13: Notch 9.76 Hz to 1.028 kHz, updates output
// RQ14: New-data strobe; mark words after changes
`timescale 1ns/100ps
`include "sdf_cfg.svh"

module sdf_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Configuration from the control logic
    input wire sdf_pkg::sdf_cfg_t cfg_i,
    // Modulator bit stream pin
    input wire logic mod_bit_i,
    // Timing strobes towards the modulator
    output logic mod_tick_o,
    output logic samp_tick_o,
    // Output data register
    output sdf_pkg::sdf_word_t word_o,
    output logic new_data_o,
    // Status
    output logic settled_o,
    output logic fsw_clamped_o,
    output logic [4:0] samp_per_cycle_o
);
    import sdf_pkg::*;

    // Pin synchroniser
    logic bit_meta_q;
    logic bit_sync_q;

    // Configuration tracking
    sdf_cfg_t cfg_q;
    logic [`SDF_FSW_W-1:0] decim_q;
    logic [`SDF_FSW_W-1:0] decim_d;
    logic clamp_q;

    // Strobes from the tick generator
    logic mod_tick;
    logic samp_tick;
    logic mod_tick_q;
    logic samp_tick_q;

    // Sample counting per modulator cycle
    logic [4:0] samp_cnt_q;
    logic [4:0] samp_cnt_d;
    logic [4:0] samp_per_cycle_q;

    // Filter core
    logic core_stb;
    sdf_acc_t core_out;

    // Settling control
    sdf_state_t state_q;
    sdf_state_t state_d;
    logic [`SDF_SETTLE_W-1:0] settle_q;
    logic [`SDF_SETTLE_W-1:0] settle_d;
    logic flush;

    // Output register
    sdf_word_t word_q;
    logic new_data_q;
    logic settled_q;

    // The modulator bit crosses from the analog side
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_meta_q <= 1'b0;
            bit_sync_q <= 1'b0;
        end else begin
            bit_meta_q <= mod_bit_i;
            bit_sync_q <= bit_meta_q;
        end
    end

    // Out-of-range select words are pinned to the legal notch range
    wire fsw_low = cfg_i.filter_select_word < `SDF_FSW_MIN;
    wire fsw_high = cfg_i.filter_select_word > `SDF_FSW_MAX;
    wire fsw_bad = fsw_low || fsw_high;
    assign decim_d = fsw_low ? `SDF_FSW_MIN :
                     fsw_high ? `SDF_FSW_MAX :
                     cfg_i.filter_select_word; // see RQ4 RQ13

    // Any change of select word, gain or channel restarts the filter
    wire cfg_chg = (cfg_i != cfg_q); // see RQ14

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_q <= '{filter_select_word: `SDF_FSW_RST, gain_code: 3'h0, chan_sel: 1'b0};
            decim_q <= `SDF_FSW_RST;
            clamp_q <= 1'b0;
        end else begin
            cfg_q <= cfg_i;
            decim_q <= decim_d;
            clamp_q <= fsw_bad;
        end
    end

    sdf_tick_gen u_tick (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .gain_code_i(cfg_q.gain_code),
        .mod_tick_o(mod_tick),
        .samp_tick_o(samp_tick)
    );

    // Count input samples taken within each modulator cycle
    assign samp_cnt_d = mod_tick ? 5'(samp_tick) :
                        (samp_tick ? samp_cnt_q + 5'h01 : samp_cnt_q); // see RQ2

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mod_tick_q <= 1'b0;
            samp_tick_q <= 1'b0;
            samp_cnt_q <= 5'h00;
            samp_per_cycle_q <= 5'h00;
        end else begin
            mod_tick_q <= mod_tick;
            samp_tick_q <= samp_tick;
            samp_cnt_q <= samp_cnt_d;
            if (mod_tick) samp_per_cycle_q <= samp_cnt_q;
        end
    end

    // Wide accumulators leave headroom well past full scale; no
    // saturation logic is needed since wraparound cancels in the combs.
    // The decimator alone cannot reject noise near multiples of the
    // modulator rate; that is left to an analog prefilter.
    sdf_sinc3 u_core (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .clear_i(flush), // see RQ11 RQ12
        .decim_i(decim_q),
        .tick_i(mod_tick),
        .bit_i(bit_sync_q),
        .out_stb_o(core_stb),
        .out_o(core_out)
    );

    // Settling sequence
    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        case (state_q)
            SDF_ST_FLUSH: begin
                settle_d = '0;
                state_d = SDF_ST_SETTLE;
            end
            SDF_ST_SETTLE: begin
                if (core_stb) begin
                    settle_d = settle_q + 1'b1;
                    if (settle_q == `SDF_SETTLE_WORDS - 1'b1) begin
                        state_d = SDF_ST_RUN; // see RQ8
                    end
                end
            end
            SDF_ST_RUN: begin
                settle_d = settle_q;
            end
            default: begin
                state_d = SDF_ST_FLUSH;
                settle_d = '0;
            end
        endcase
        if (cfg_chg) begin
            state_d = SDF_ST_FLUSH; // see RQ10 RQ14
        end
    end

    assign flush = (state_q == SDF_ST_FLUSH);

    // Words reaching the output before settling carry valid low
    wire word_ok = (state_d == SDF_ST_RUN) && !cfg_chg; // see RQ9

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= SDF_ST_FLUSH;
            settle_q <= '0;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
        end
    end

    // Output register updates once per notch period
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            word_q <= '0;
            new_data_q <= 1'b0;
            settled_q <= 1'b0;
        end else begin
            new_data_q <= core_stb && !flush; // see RQ13 RQ14
            if (core_stb && !flush) begin
                word_q.data <= core_out; // see RQ7
                word_q.valid <= word_ok;
            end
            settled_q <= (state_d == SDF_ST_RUN);
        end
    end

    assign mod_tick_o = mod_tick_q;
    assign samp_tick_o = samp_tick_q;
    assign word_o = word_q;
    assign new_data_o = new_data_q;
    assign settled_o = settled_q;
    assign fsw_clamped_o = clamp_q;
    assign samp_per_cycle_o = samp_per_cycle_q;
endmodule

// File: verif/sdf_mod_model.sv
// Behavioural modulator feeding the filter bit stream
`timescale 1ns/100ps

module sdf_mod_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Cycle strobe and pattern: 0 zeros, 1 ones, 2/3 toggling
    input wire logic tick_i,
    input wire logic [1:0] mode_i,
    // Bit towards the filter
    output logic bit_o
);
    // One decision per modulator cycle, never between ticks
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_o <= 1'b0;
        end else if (tick_i) begin
            bit_o <= mode_i[1] ? ~bit_o : mode_i[0];
        end
    end
endmodule

// File: verif/sdf_top_sva.sv
// Port assertions for the sinc-cubed filter top
`timescale 1ns/100ps

module sdf_top_sva
    import sdf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire sdf_cfg_t cfg_i,
    input wire logic mod_tick_o,
    input wire logic samp_tick_o,
    input wire sdf_word_t word_o,
    input wire logic new_data_o,
    input wire logic settled_o,
    input wire logic fsw_clamped_o,
    input wire logic [4:0] samp_per_cycle_o
);
    logic [12:0] mcnt_q;
    logic [12:0] scnt_q;
    logic [13:0] gstab_q;
    logic [2:0] gain_q;
    logic seen_q;
    wire oor = cfg_i.filter_select_word < 12'h013 || cfg_i.filter_select_word > 12'h7D0;
    wire [1:0] gmin = cfg_i.gain_code > 3'h3 ? 2'h3 : cfg_i.gain_code[1:0];
    wire [12:0] sper = 13'h0A00 >> gmin;
    wire [4:0] spc_exp = 5'h02 << gmin;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mcnt_q <= 13'h0000;
            scnt_q <= 13'h0000;
            gstab_q <= 14'h0000;
            gain_q <= 3'h0;
            seen_q <= 1'b0;
        end else begin
            mcnt_q <= mod_tick_o ? 13'h0000 : mcnt_q + 13'h0001;
            scnt_q <= samp_tick_o ? 13'h0000 : scnt_q + 13'h0001;
            gain_q <= cfg_i.gain_code;
            seen_q <= seen_q | mod_tick_o;
            // Saturate so a long steady run keeps the flag
            if (cfg_i.gain_code != gain_q) begin
                gstab_q <= 14'h0000;
            end else if (gstab_q != 14'h3FFF) begin
                gstab_q <= gstab_q + 14'h0001;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_mod_tick_period: assert property (seen_q |-> mod_tick_o == (mcnt_q == 13'h13FF))
        else $error("modulator tick period wrong");
    a_samp_tick_period: assert property ((samp_tick_o && gstab_q > 14'h1800) |-> scnt_q == sper - 13'h0001)
        else $error("sample tick period wrong");
    a_spc_gain: assert property (gstab_q > 14'h3000 |-> samp_per_cycle_o == spc_exp)
        else $error("samples per cycle wrong");
    a_data_one_pulse: assert property (new_data_o |=> !new_data_o)
        else $error("new data longer than one cycle");
    a_word_held: assert property (!new_data_o |-> $stable(word_o))
        else $error("word changed without strobe");
    a_valid_settled: assert property (new_data_o |-> word_o.valid == settled_o)
        else $error("valid mark disagrees with settled");
    a_cfg_unsettle: assert property (cfg_i != $past(cfg_i) |-> ##[1:2] !settled_o)
        else $error("settled kept after change");
    a_clamp_set: assert property (oor && $past(oor) && $past(oor, 2) |-> fsw_clamped_o)
        else $error("clamp flag missing");
    a_clamp_clear: assert property (!oor && !$past(oor) && !$past(oor, 2) |-> !fsw_clamped_o)
        else $error("clamp flag spurious");
endmodule

bind sdf_top sdf_top_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg_i),
    .mod_tick_o(mod_tick_o), .samp_tick_o(samp_tick_o), .word_o(word_o),
    .new_data_o(new_data_o), .settled_o(settled_o), .fsw_clamped_o(fsw_clamped_o),
    .samp_per_cycle_o(samp_per_cycle_o));

// File: verif/tb.sv
// Self-checking bench for the sinc-cubed decimation filter
`timescale 1ns/100ps

module tb;
    import sdf_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    sdf_cfg_t cfg = {12'h0C3, 3'h0, 1'b0};
    logic [1:0] mode = 2'h1;
    logic mod_bit, mod_tick, samp_tick, new_data, settled, clamped;
    logic [4:0] spc;
    sdf_word_t word;
    int n_mismatch = 0;
    int checked = 0;
    int cyc_n = 0;
    int seed = 32'h5D24152C;
    int gq[$] = '{0, 1, 2};

    sdf_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg), .mod_bit_i(mod_bit),
        .mod_tick_o(mod_tick), .samp_tick_o(samp_tick), .word_o(word),
        .new_data_o(new_data), .settled_o(settled), .fsw_clamped_o(clamped),
        .samp_per_cycle_o(spc));
    sdf_mod_model u_mod (.clk_i(clk_i), .rst_b_i(rst_b_i), .tick_i(mod_tick),
        .mode_i(mode), .bit_o(mod_bit));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_n++;
    end

    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int k, input int lim);
        if (k >= lim) begin
            n_mismatch++;
            stop_test();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic set_cfg(input logic [11:0] f, input logic [2:0] g);
        cyc(1);
        cfg = {f, g, 1'($random(seed))};
        mode = 2'($random(seed));
    endtask
    // Window of exactly one modulator cycle, so tick phase does not matter
    task automatic ticks(input int g);
        int k;
        int c;
        int s;
        int e;
        k = 0;
        c = 0;
        s = 0;
        e = 2 << (g > 3 ? 3 : g);
        cyc(200);
        while (mod_tick !== 1'b1 && k < 6000) begin
            cyc(1);
            k++;
        end
        tmo(k, 6000);
        do begin
            cyc(1);
            c++;
            s += samp_tick;
        end while (mod_tick !== 1'b1 && c < 6000);
        chk(c, 5120);
        chk(s, e);
        cyc(3);
        chk(spc, e);
    endtask

    initial begin
        int f;
        int g;
        int k;
        int t0;
        cyc(3);
        chk({word, new_data, settled, clamped, spc}, 64'h0);
        cyc(3);
        rst_b_i = 1'b1;
        foreach (gq[i]) begin
            set_cfg(12'h0C3, gq[i][2:0]);
            ticks(gq[i]);
        end
        $display("test gains done");
        f = 2001 + $unsigned($random(seed)) % 2095;
        set_cfg(f[11:0], 3'h0);
        cyc(3);
        chk(clamped, 1);
        f = $unsigned($random(seed)) % 19;
        g = 3 + $unsigned($random(seed)) % 5;
        set_cfg(f[11:0], g[2:0]);
        mode = 2'h1;
        t0 = cyc_n;
        cyc(3);
        chk({clamped, settled}, 2'h2);
        ticks(g);
        k = 0;
        while (new_data !== 1'b1 && k < 110000) begin
            cyc(1);
            k++;
        end
        tmo(k, 110000);
        // Nineteen modulator cycles per word at the lowest legal select
        chk((cyc_n - t0) >= 18 * 5120 && (cyc_n - t0) <= 20 * 5120, 1);
        chk(word.valid, 0);
        chk($signed(word.data) > 0 && $signed(word.data) <= 19 * 19 * 19, 1);
        $display("test first word done");
        stop_test();
    end
endmodule
